// [hdl/mpt_pwm_timer.v]
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mpt_regs.vh"
module mpt_pwm_timer #(
  parameter NT = 5,
  parameter W  = 16
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  input  wire [1:0]  external_timer_clock_input,
  output reg  [3:0]  timer_output,
  output wire [4:0]  timer_irq
);
  // ==========================================================
  // registers
  reg  [23:0]     pre_cfg_r;
  reg  [19:0]     div_cfg_r;
  reg  [20:0]     ctl_r;
  reg  [W-1:0]    cbuf_r [0:NT-1];
  reg  [W-1:0]    mbuf_r [0:NT-1];
  reg  [31:0]     rd_nxt;
  reg             err_nxt;
  reg             ch_hit;
  reg  [2:0]      chn;
  wire [NT*W-1:0] cnt_flat;
  wire [NT-1:0]   ch_out;
  wire [3:0]      tap0;
  wire [3:0]      tap1;
  wire [1:0]      ext_tick;
  wire            setup;
  wire            wr_en;
  integer         i;

  // ==========================================================
  // apb slave: zero wait states; read data latched in setup
  assign pready = 1'b1;
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pwrite & ~pslverr;

  always @* begin
    rd_nxt  = 32'h0;
    err_nxt = 1'b0;
    chn     = paddr[6:4] - 3'h1;
    ch_hit  = ~paddr[7] & (paddr[6:4] >= 3'h1) & (paddr[6:4] <= 3'h5);
    if (paddr[1:0] != 2'h0) begin
      err_nxt = 1'b1;
    end else if (paddr == `MPT_OFF_PRESCALE) begin
      rd_nxt = {8'h0, pre_cfg_r};
    end else if (paddr == `MPT_OFF_DIVIDER) begin
      rd_nxt = {12'h0, div_cfg_r};
    end else if (paddr == `MPT_OFF_CONTROL) begin
      rd_nxt = {11'h0, ctl_r};
    end else if (ch_hit) begin
      case (paddr[3:2])
        `MPT_CH_CBUF: begin
          rd_nxt = {16'h0, cbuf_r[chn]};
        end
        `MPT_CH_MBUF: begin
          rd_nxt = {16'h0, mbuf_r[chn]};
        end
        `MPT_CH_OBS: begin
          rd_nxt = {16'h0, cnt_flat[{chn, 4'h0} +: W]};
        end
        default: begin
          err_nxt = 1'b1;
        end
      endcase
    end else begin
      err_nxt = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0 : rd_nxt;
      pslverr <= err_nxt;
    end
  end

  // ==========================================================
  // register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cfg_r <= `MPT_RST_PRESCALE;
      div_cfg_r <= `MPT_RST_DIVIDER;
      ctl_r     <= `MPT_RST_CONTROL;
      for (i = 0; i < NT; i = i + 1) begin
        cbuf_r[i] <= `MPT_RST_BUF;
        mbuf_r[i] <= `MPT_RST_BUF;
      end
    end else if (wr_en) begin
      if (paddr == `MPT_OFF_PRESCALE) begin
        pre_cfg_r <= pwdata[23:0];
      end else if (paddr == `MPT_OFF_DIVIDER) begin
        div_cfg_r <= pwdata[19:0];
      end else if (paddr == `MPT_OFF_CONTROL) begin
        ctl_r <= pwdata[20:0];
      end else if (ch_hit && paddr[3:2] == `MPT_CH_CBUF) begin
        cbuf_r[chn] <= pwdata[W-1:0];
      end else if (ch_hit && paddr[3:2] == `MPT_CH_MBUF) begin
        mbuf_r[chn] <= pwdata[W-1:0];
      end
    end
  end

  // ==========================================================
  // prescalers
  mpt_prescaler u_pre0 (
    .pclk     (pclk),
    .presetn  (presetn),
    .pre_val  (pre_cfg_r[`MPT_PRE0_LSB +: 8]),
    .ext_clk  (external_timer_clock_input[0]),
    .tap_tick (tap0),
    .ext_tick (ext_tick[0])
  );

  mpt_prescaler u_pre1 (
    .pclk     (pclk),
    .presetn  (presetn),
    .pre_val  (pre_cfg_r[`MPT_PRE1_LSB +: 8]),
    .ext_clk  (external_timer_clock_input[1]),
    .tap_tick (tap1),
    .ext_tick (ext_tick[1])
  );

  // ==========================================================
  // timer channels
  genvar g;
  generate
    for (g = 0; g < NT; g = g + 1) begin : g_ch
      wire [3:0] sel;
      wire [3:0] taps;
      wire       ext;
      wire       tick;
      wire [3:0] ctl;
      assign sel  = div_cfg_r[g*`MPT_DIV_W +: `MPT_DIV_W];
      assign taps = (g < 2) ? tap0 : tap1;
      assign ext  = (g < 2) ? ext_tick[0] : ext_tick[1];
      assign tick = (sel >= `MPT_DIV_EXT_MIN) ? ext : taps[sel[1:0]];
      assign ctl  = ctl_r[g*`MPT_CTL_W +: `MPT_CTL_W];
      mpt_channel #(
        .W (W)
      ) u_ch (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick     (tick),
        .start    (ctl[`MPT_CTL_START]),
        .manual   (ctl[`MPT_CTL_MANUAL]),
        .auto_rel (ctl[`MPT_CTL_AUTO]),
        .invert   (ctl[`MPT_CTL_INVERT]),
        .cnt_buf  (cbuf_r[g]),
        .cmp_buf  (mbuf_r[g]),
        .count    (cnt_flat[g*W +: W]),
        .out      (ch_out[g]),
        .irq      (timer_irq[g])
      );
    end
  endgenerate

  // ==========================================================
  // dead zone on timer 0
  // gap counted in pclk cycles, so its length of dead zone value + 1 cycles does not follow the tick rate
  reg       dz_lvl_r;
  reg [7:0] dz_cnt_r;
  wire      dz_en;

  assign dz_en = ctl_r[`MPT_CTL_DZ_EN];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dz_lvl_r     <= 1'b0;
      dz_cnt_r     <= 8'h00;
      timer_output <= 4'h0;
    end else begin
      if (ch_out[0] != dz_lvl_r) begin
        dz_lvl_r <= ch_out[0];
        dz_cnt_r <= pre_cfg_r[`MPT_DZ_LSB +: 8];
      end else if (dz_cnt_r != 8'h00) begin
        dz_cnt_r <= dz_cnt_r - 8'h01;
      end
      // during the gap neither side is on
      if (dz_en) begin
        timer_output[0] <= dz_lvl_r & (dz_cnt_r == 8'h00) & (ch_out[0] == dz_lvl_r);
        timer_output[1] <= ~dz_lvl_r & (dz_cnt_r == 8'h00) & (ch_out[0] == dz_lvl_r);
      end else begin
        timer_output[1:0] <= ch_out[1:0];
      end
      timer_output[3:2] <= ch_out[3:2];
    end
  end
endmodule
`default_nettype wire

// [hdl/mpt_regs.vh]
`ifndef MPT_REGS_VH
`define MPT_REGS_VH

// ==========================================================
// register offsets
`define MPT_OFF_PRESCALE 8'h00
`define MPT_OFF_DIVIDER  8'h04
`define MPT_OFF_CONTROL  8'h08
// per-timer block n at 8'h10 * (n + 1)
`define MPT_CH_CBUF      2'h0
`define MPT_CH_MBUF      2'h1
`define MPT_CH_OBS       2'h2

// ==========================================================
// fields
`define MPT_PRE0_LSB     0
`define MPT_PRE1_LSB     8
`define MPT_DZ_LSB       16
`define MPT_DIV_W        4
`define MPT_CTL_W        4
`define MPT_CTL_START    0
`define MPT_CTL_MANUAL   1
`define MPT_CTL_INVERT   2
`define MPT_CTL_AUTO     3
`define MPT_CTL_DZ_EN    20
`define MPT_DIV_EXT_MIN  4'h4

// ==========================================================
// reset values
`define MPT_RST_PRESCALE 24'h000000
`define MPT_RST_DIVIDER  20'h00000
`define MPT_RST_CONTROL  21'h000000
`define MPT_RST_BUF      16'h0000

`endif

// [hdl/mpt_prescaler.v]
`timescale 1ns/1ps
`default_nettype none
module mpt_prescaler (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [7:0] pre_val,
  input  wire       ext_clk,
  output reg  [3:0] tap_tick,
  output reg        ext_tick
);
  reg [7:0] pcnt_r;
  reg [3:0] dcnt_r;
  reg       ext_d_r;
  wire      pre_tick;

  // ==========================================================
  // prescaler: one pulse every pre_val+1 clocks
  // >= keeps the counter from running away when pre_val shrinks
  assign pre_tick = (pcnt_r >= pre_val);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcnt_r   <= 8'h00;
      dcnt_r   <= 4'h0;
      ext_d_r  <= 1'b0;
      tap_tick <= 4'h0;
      ext_tick <= 1'b0;
    end else begin
      pcnt_r   <= pre_tick ? 8'h00 : pcnt_r + 8'h01;
      ext_d_r  <= ext_clk;
      ext_tick <= ext_clk & ~ext_d_r;
      if (pre_tick) begin
        dcnt_r <= dcnt_r + 4'h1;
      end
      // taps: /2 /4 /8 /16 of the prescaler output
      tap_tick[0] <= pre_tick & dcnt_r[0];
      tap_tick[1] <= pre_tick & (&dcnt_r[1:0]);
      tap_tick[2] <= pre_tick & (&dcnt_r[2:0]);
      tap_tick[3] <= pre_tick & (&dcnt_r[3:0]);
    end
  end
endmodule
`default_nettype wire

// [hdl/mpt_channel.v]
`timescale 1ns/1ps
`default_nettype none
module mpt_channel #(
  parameter W = 16
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         tick,
  input  wire         start,
  input  wire         manual,
  input  wire         auto_rel,
  input  wire         invert,
  input  wire [W-1:0] cnt_buf,
  input  wire [W-1:0] cmp_buf,
  output reg  [W-1:0] count,
  output reg          out,
  output reg          irq
);
  reg [W-1:0] cmp_r;
  reg         raw_r;
  reg         start_d_r;
  wire        start_rise;
  wire [W-1:0] dec;

  assign start_rise = start & ~start_d_r;
  assign dec        = count - {{(W-1){1'b0}}, 1'b1};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count     <= {W{1'b0}};
      cmp_r     <= {W{1'b0}};
      raw_r     <= 1'b0;
      start_d_r <= 1'b0;
      out       <= 1'b0;
      irq       <= 1'b0;
    end else begin
      start_d_r <= start;
      irq       <= 1'b0;
      // inverter acts on the pin even while stopped
      out       <= raw_r ^ invert;
      if (manual) begin
        count <= cnt_buf;
        cmp_r <= cmp_buf;
        raw_r <= (cnt_buf <= cmp_buf);
      end else if (start_rise && count == {W{1'b0}}) begin
        count <= cnt_buf;
        cmp_r <= cmp_buf;
        raw_r <= (cnt_buf <= cmp_buf);
      end else if (start && tick) begin
        if (count == {W{1'b0}}) begin
          if (auto_rel) begin
            // buffers reach the live registers here, on a manual load and on a start from zero
            count <= cnt_buf;
            cmp_r <= cmp_buf;
            raw_r <= (cnt_buf <= cmp_buf);
          end
        end else begin
          count <= dec;
          if (dec == cmp_r) begin
            raw_r <= 1'b1;
          end
          if (dec == {W{1'b0}}) begin
            irq <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verif/mpt_pwm_timer_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ====
// checker on the timer bank ports
module mpt_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  external_timer_clock_input,
  input wire logic [3:0]  timer_output,
  input wire logic [4:0]  timer_irq
);
  // shadow of the control word, so rules can key on software intent
  logic [20:0] ctl_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= 21'h000000;
    end else if (psel && penable && pwrite && paddr == 8'h08) begin
      ctl_r <= pwdata[20:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence obs_setup; psel && !penable && paddr == 8'h38; endsequence
  sequence t2_idle; !ctl_r[8] && !ctl_r[9] && $stable(ctl_r[10]); endsequence
  sequence oneshot_end; timer_irq[2] && !ctl_r[11]; endsequence
  rst_clear_a: assert property (!$past(presetn) |-> {timer_output, timer_irq} == 9'h000)
    else $error("outputs not clear after reset");
  irq_pulse_a: assert property ((timer_irq & $past(timer_irq)) == 5'h00)
    else $error("interrupt request longer than one cycle");
  obs_read_a: assert property (obs_setup |=> pready && !pslverr)
    else $error("observation read refused");
  stop_quiet_a: assert property ((!ctl_r[8]) [*3] |-> !timer_irq[2])
    else $error("stopped timer raised a request");
  // a match on the last running tick still needs three edges to reach the pin
  hold_level_a: assert property (t2_idle [*4] |-> $stable(timer_output[2]))
    else $error("idle timer output moved");
  inv_flip_a: assert property ($changed(ctl_r[10]) && !ctl_r[8] && !ctl_r[9]
    |-> ##[1:2] $changed(timer_output[2])) else $error("inverter did not flip output");
  dz_apart_a: assert property (ctl_r[20] && $past(ctl_r[20], 3)
    |-> !(timer_output[0] && timer_output[1])) else $error("dead zone pair both on");
  oneshot_stop_a: assert property (oneshot_end ##1 (ctl_r[8] && !ctl_r[9] && !ctl_r[11]) [*8]
    |-> !timer_irq[2]) else $error("one-shot timer reloaded");
endmodule
bind mpt_pwm_timer mpt_chk mpt_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .external_timer_clock_input(external_timer_clock_input),
  .timer_output(timer_output), .timer_irq(timer_irq));
`default_nettype wire

// [verif/mpt_irq_sink.sv]
`timescale 1ns/1ps
`default_nettype none
// ====
// interrupt controller stand-in: counts timer 2 requests
module mpt_irq_sink (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [4:0] timer_irq,
  output var  logic [7:0] hits2
);
  // a pulse lasts one cycle, so each high sample is one request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hits2 <= 8'h00;
    end else if (timer_irq[2]) begin
      hits2 <= hits2 + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [verif/mpt_pwm_timer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ====
// timer bank bench
module mpt_pwm_timer_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        etog = 1'b0;
  logic        ext_on = 1'b0;
  logic [1:0]  ediv = 2'h0;
  logic [3:0]  timer_output;
  logic [4:0]  timer_irq;
  logic [7:0]  hits2;
  logic [31:0] rdat;
  logic        rerr;
  int          n_errors = 0;
  int          num_checks = 0;
  always #5 pclk = ~pclk;
  // external source gives a rising edge every six cycles while enabled
  always @(posedge pclk) begin
    ediv <= (ediv == 2'h2) ? 2'h0 : ediv + 2'h1;
    if (ediv == 2'h2) begin
      etog <= ~etog & ext_on;
    end
  end
  mpt_pwm_timer mpt_pwm_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_timer_clock_input({etog, etog}),
    .timer_output(timer_output), .timer_irq(timer_irq));
  mpt_irq_sink mpt_irq_sink_i (.pclk(pclk), .presetn(presetn), .timer_irq(timer_irq),
    .hits2(hits2));
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // cycles between two consecutive timer 2 requests
  task gap(output int n);
    n = 0;
    while (timer_irq[2] !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    n = 1;
    while (timer_irq[2] !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task t_reset;
    chk("outputs", 32'h0, {timer_output, timer_irq});
    apb(1'b0, 8'h38, 32'h0);
    chk("obs", 32'h0, rdat);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, rerr});
  endtask
  task t_rate;
    int n;
    apb(1'b1, 8'h00, 32'h00000100);
    apb(1'b1, 8'h30, 32'h3);
    apb(1'b1, 8'h34, 32'h1);
    apb(1'b0, 8'h30, 32'h0);
    chk("reload buf", 32'h3, rdat);
    apb(1'b1, 8'h08, 32'h200);
    apb(1'b1, 8'h08, 32'h900);
    for (int d = 0; d < 5; d++) begin
      ext_on <= (d == 4);
      apb(1'b1, 8'h04, 32'(d) << 8);
      gap(n);
      gap(n);
      chk("period", (d < 4) ? 32'(8 * (2 << d)) : 32'd24, 32'(n));
    end
    apb(1'b0, 8'h38, 32'h0);
    chk("obs range", 32'h1, {31'h0, rdat <= 32'h3});
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h30, 32'h5);
    gap(n);
    gap(n);
    chk("new period", 32'd24, 32'(n));
  endtask
  task t_stop;
    logic [7:0]  h;
    logic [31:0] c;
    apb(1'b1, 8'h08, 32'h800);
    apb(1'b0, 8'h38, 32'h0);
    h = hits2;
    c = rdat;
    repeat (40) @(posedge pclk);
    apb(1'b0, 8'h38, 32'h0);
    chk("frozen obs", c, rdat);
    chk("no request", {24'h0, h}, {24'h0, hits2});
  endtask
  task t_oneshot;
    logic [7:0] h;
    apb(1'b1, 8'h30, 32'h3);
    apb(1'b1, 8'h08, 32'h200);
    apb(1'b0, 8'h38, 32'h0);
    chk("manual load", 32'h3, rdat);
    h = hits2;
    apb(1'b1, 8'h08, 32'h100);
    repeat (100) @(posedge pclk);
    chk("one request", 32'h1, {24'h0, hits2 - h});
    apb(1'b0, 8'h38, 32'h0);
    chk("stopped at 0", 32'h0, rdat);
  endtask
  task t_inv;
    logic o;
    o = timer_output[2];
    apb(1'b1, 8'h08, 32'h400);
    repeat (3) @(posedge pclk);
    chk("inverted", {31'h0, ~o}, {31'h0, timer_output[2]});
    apb(1'b1, 8'h08, 32'h000);
    repeat (3) @(posedge pclk);
    chk("restored", {31'h0, o}, {31'h0, timer_output[2]});
  endtask
  task t_dz;
    int both;
    int tog;
    int run;
    int short_gaps;
    both = 0;
    tog = 0;
    // a gap already open when sampling starts is partial and not judged
    run = -1000;
    short_gaps = 0;
    apb(1'b1, 8'h00, 32'h00020100);
    apb(1'b1, 8'h10, 32'h9);
    apb(1'b1, 8'h14, 32'h4);
    apb(1'b1, 8'h08, 32'h2);
    apb(1'b1, 8'h08, 32'h100009);
    repeat (200) begin
      @(posedge pclk);
      both += (timer_output[0] & timer_output[1]);
      tog += (timer_output[0] !== timer_output[1]);
      if (timer_output[1:0] == 2'b00) begin
        run++;
      end else begin
        short_gaps += (run > 0 && run < 2);
        run = 0;
      end
    end
    chk("pair overlap", 32'h0, 32'(both));
    chk("pair active", 32'h1, {31'h0, tog > 0});
    chk("short dead gap", 32'h0, 32'(short_gaps));
  endtask
  task complete_run;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rate();
    t_stop();
    t_oneshot();
    t_inv();
    t_dz();
    complete_run();
  end
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
